// ### qhbc_device.sv
/*
 * device end: output state per channel, reset and sleep handling,
 * charge-pump state, overcurrent latch, thermal and undervoltage shutdown,
 * open-drain fault output.
 * assumes pins arrive synchronous to core_clk_i and the analog side
 * supplies current-limit, temperature and supply-good levels.
 * limitations: the wake-up count is fixed by a parameter, and the
 * deglitch and trip point come from package constants; the analog
 * current limit itself lives outside this block.
 * the fault pin never drives high; the pull-up sits off chip.
 */
// Summary of operation
// - enable low floats output, else follows input
// - host slow decay: PWM on one input
// - host forward fast decay: PWM both enables
// - host reverse fast decay: PWM both enables
// - charge pump off while sleep low
// - reset pin reinitializes and disables bridges
// - all control inputs ignored during reset; the sleep pin still stops pump and clocks and restarts wake-up
// - sleep disables bridges, pump, clocks
// - sleep ignores inputs until sleep high
// - about one millisecond wake-up before operating
// - host drives reset and sleep high
// - regulator stays on during sleep
// - persistent limit disables channel, pulls fault
// - overcurrent deglitch is five microseconds
// - overcurrent latched until reset or power-cycle
// - high or low side trips alike
// - overtemperature disables all, pulls fault
// - thermal shutdown recovers when cooled
// - thermal trip above 150 degrees
// - undervoltage disables, resets logic, pulls fault
// - undervoltage recovers when supply returns
// - fault output open-drain, low on faults
`timescale 1ns/100ps
module qhbc_device
    import qhbc_pkg::*;
#(
    parameter int WAKE_CYCLES = QHBC_WAKE_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    qhbc_if.device pins,
    input wire logic [3:0] hs_limit_i,
    input wire logic [3:0] ls_limit_i,
    input wire logic [QHBC_TEMP_W-1:0] die_temp_i,
    input wire logic supply_good_i,
    output logic [3:0] channel_output_o,
    output logic [3:0] channel_output_oe_o,
    output logic charge_pump_on_o,
    output logic regulator_on_o,
    output logic clocks_running_o,
    output logic operational_o
);

    qhbc_state_t state_q;
    logic [15:0] wake_cnt_q;
    logic [3:0] ocp_trip_q;
    logic [QHBC_OCP_CNT_W-1:0] ocp_cnt_q [QHBC_CHANNELS];
    logic hot_q;
    logic fault_q;
    logic fault_oe_q;
    logic logic_rst;
    logic awake;

    // ----------------------------------------------------------------
    // counter helpers
    // ----------------------------------------------------------------
    // true on the last cycle of a span of the given length
    function automatic logic count_done(input int cnt, input int span);
        return cnt >= span - 1;
    endfunction

    // ----------------------------------------------------------------
    // reset conditions
    // ----------------------------------------------------------------
    // pin reset and undervoltage both reinitialize the core logic
    assign logic_rst = !pins.active_low_reset_input_n || !supply_good_i;
    assign awake = pins.sleep_request_input_n;

    // ----------------------------------------------------------------
    // sleep and wake-up sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= QHBC_ST_ASLEEP;
            wake_cnt_q <= 16'h0000;
        end else if (!awake) begin
            state_q <= QHBC_ST_ASLEEP;
            wake_cnt_q <= 16'h0000;
        end else begin
            unique case (state_q)
                QHBC_ST_ASLEEP: begin
                    state_q <= QHBC_ST_WAKING;
                    wake_cnt_q <= 16'h0000;
                end
                QHBC_ST_WAKING: begin
                    // counter runs through a held reset: only sleep restarts it
                    if (count_done(32'(wake_cnt_q), WAKE_CYCLES)) begin
                        state_q <= QHBC_ST_ACTIVE;
                    end else begin
                        wake_cnt_q <= wake_cnt_q + 16'h0001;
                    end
                end
                QHBC_ST_ACTIVE: begin
                    state_q <= QHBC_ST_ACTIVE;
                end
                default: begin
                    state_q <= QHBC_ST_ASLEEP;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // overcurrent deglitch and latch
    // ----------------------------------------------------------------
    // counter width must hold the whole deglitch count
    for (genvar c = 0; c < QHBC_CHANNELS; c++) begin : g_ocp
        logic limit;
        assign limit = hs_limit_i[c] || ls_limit_i[c];
        always_ff @(posedge core_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                ocp_cnt_q[c] <= '0;
                ocp_trip_q[c] <= 1'b0;
            end else if (logic_rst) begin
                ocp_cnt_q[c] <= '0;
                ocp_trip_q[c] <= 1'b0;
            end else if (state_q != QHBC_ST_ACTIVE) begin
                ocp_cnt_q[c] <= '0;
            end else if (!limit) begin
                ocp_cnt_q[c] <= '0;
            end else if (count_done(32'(ocp_cnt_q[c]), QHBC_OCP_CYCLES)) begin
                ocp_trip_q[c] <= 1'b1;
            end else begin
                ocp_cnt_q[c] <= ocp_cnt_q[c] + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // thermal shutdown, clears on its own once cooled
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hot_q <= 1'b0;
        end else begin
            // strictly above the trip point
            hot_q <= die_temp_i > QHBC_TSD_TRIP;
        end
    end

    // ----------------------------------------------------------------
    // bridge outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            channel_output_o <= 4'h0;
            channel_output_oe_o <= 4'h0;
        // sleep pin gates directly so bridges drop on the first sleep edge
        end else if (logic_rst || !awake || hot_q
                     || state_q != QHBC_ST_ACTIVE) begin
            // inputs ignored; all bridges off
            channel_output_o <= 4'h0;
            channel_output_oe_o <= 4'h0;
        end else begin
            channel_output_o <= pins.channel_level_input;
            channel_output_oe_o <= pins.channel_output_enable
                & ~ocp_trip_q;
        end
    end

    // ----------------------------------------------------------------
    // power status
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            charge_pump_on_o <= 1'b0;
            clocks_running_o <= 1'b0;
            regulator_on_o <= 1'b0;
            operational_o <= 1'b0;
        end else begin
            charge_pump_on_o <= awake;
            clocks_running_o <= awake;
            // regulator is never stopped, not even in sleep
            regulator_on_o <= 1'b1;
            operational_o <= state_q == QHBC_ST_ACTIVE && !logic_rst;
        end
    end

    // ----------------------------------------------------------------
    // open-drain fault
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_q <= 1'b0;
            fault_oe_q <= 1'b0;
        end else begin
            fault_q <= 1'b0;
            fault_oe_q <= hot_q || !supply_good_i || (|ocp_trip_q);
        end
    end

    assign pins.fault_output_o = fault_q;
    assign pins.fault_output_oe = fault_oe_q;

endmodule

// ### qhbc_pkg.sv
/*
 * package of the quad half-bridge control block: channel count, timing
 * constants, drive modes and device states.
 * assumes a single 50 MHz core clock shared by both ends.
 */
package qhbc_pkg;

    localparam int QHBC_CHANNELS = 4;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int QHBC_CLK_MHZ = 50;
    localparam int QHBC_CLK_PERIOD_NS = 20;
    // wake-up time after sleep, in microseconds (1 ms)
    localparam int QHBC_WAKE_US = 1000;
    localparam int QHBC_WAKE_CYCLES = QHBC_WAKE_US * QHBC_CLK_MHZ;
    // overcurrent deglitch, in microseconds; least time rounds up
    localparam int QHBC_OCP_DEGLITCH_US = 5;
    localparam int QHBC_OCP_CYCLES =
        (QHBC_OCP_DEGLITCH_US * 1000 + QHBC_CLK_PERIOD_NS - 1)
        / QHBC_CLK_PERIOD_NS;
    localparam int QHBC_OCP_CNT_W = 9;
    // thermal trip point, degrees Celsius
    localparam int QHBC_TSD_DEG_C = 150;
    localparam int QHBC_TEMP_W = 8;
    localparam logic [QHBC_TEMP_W-1:0] QHBC_TSD_TRIP =
        QHBC_TSD_DEG_C[QHBC_TEMP_W-1:0];

    // ----------------------------------------------------------------
    // host drive modes for the motor on channels one and two
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        QHBC_MODE_COAST,
        QHBC_MODE_FWD_SLOW,
        QHBC_MODE_REV_SLOW,
        QHBC_MODE_FWD_FAST,
        QHBC_MODE_REV_FAST
    } qhbc_mode_t;

    // device power states
    typedef enum logic [1:0] {
        QHBC_ST_ASLEEP,
        QHBC_ST_WAKING,
        QHBC_ST_ACTIVE
    } qhbc_state_t;

endpackage

// ### qhbc_if.sv
/*
 * pin-level carrier between the host controller and the driver.
 * assumes the testbench resolves the open-drain fault wire from its
 * output enable and adds the pull-up.
 */
`timescale 1ns/100ps
interface qhbc_if;
    logic [3:0] channel_level_input;
    logic [3:0] channel_output_enable;
    logic active_low_reset_input_n;
    logic sleep_request_input_n;
    logic fault_output_o;
    logic fault_output_oe;
    logic fault_output_n;

    modport device (
        input channel_level_input,
        input channel_output_enable,
        input active_low_reset_input_n,
        input sleep_request_input_n,
        output fault_output_o,
        output fault_output_oe
    );

    modport host (
        output channel_level_input,
        output channel_output_enable,
        output active_low_reset_input_n,
        output sleep_request_input_n,
        input fault_output_n
    );
endinterface

// ### qhbc_host.sv
/*
 * host end: drives the logic pins of the driver and produces the
 * slow- and fast-decay patterns for the motor on channels one and two.
 * assumes fault_output_n arrives already resolved with a pull-up.
 */
`timescale 1ns/100ps
module qhbc_host
    import qhbc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    qhbc_if.host pins,
    input wire logic run_i,
    input wire logic sleep_req_i,
    input wire logic clear_fault_i,
    input wire qhbc_mode_t mode_i,
    input wire logic pwm_i,
    input wire logic [1:0] aux_level_i,
    input wire logic [1:0] aux_enable_i,
    output logic fault_seen_o,
    output logic ready_o
);

    logic [3:0] level_q;
    logic [3:0] enable_q;
    logic reset_n_q;
    logic sleep_n_q;
    logic [15:0] wait_q;
    logic fault_seen_q;

    // ----------------------------------------------------------------
    // control pins: reset and sleep actively driven high when running
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_n_q <= 1'b0;
            sleep_n_q <= 1'b0;
        end else begin
            reset_n_q <= run_i && !clear_fault_i;
            sleep_n_q <= run_i && !sleep_req_i;
        end
    end

    // waits the wake-up time before reporting ready
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 16'h0000;
            ready_o <= 1'b0;
        end else if (!sleep_n_q) begin
            wait_q <= 16'h0000;
            ready_o <= 1'b0;
        end else if (32'(wait_q) >= QHBC_WAKE_CYCLES) begin
            ready_o <= reset_n_q;
        end else begin
            wait_q <= wait_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // drive patterns
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_q <= 4'h0;
            enable_q <= 4'h0;
        end else begin
            level_q[3:2] <= aux_level_i;
            enable_q[3:2] <= aux_enable_i;
            unique case (mode_i)
                QHBC_MODE_FWD_SLOW: begin
                    level_q[1:0] <= {1'b0, pwm_i};
                    enable_q[1:0] <= 2'h3;
                end
                QHBC_MODE_REV_SLOW: begin
                    level_q[1:0] <= {pwm_i, 1'b0};
                    enable_q[1:0] <= 2'h3;
                end
                QHBC_MODE_FWD_FAST: begin
                    level_q[1:0] <= 2'h1;
                    enable_q[1:0] <= {pwm_i, pwm_i};
                end
                QHBC_MODE_REV_FAST: begin
                    level_q[1:0] <= 2'h2;
                    enable_q[1:0] <= {pwm_i, pwm_i};
                end
                default: begin
                    level_q[1:0] <= 2'h0;
                    enable_q[1:0] <= 2'h0;
                end
            endcase
        end
    end

    // fault sampled once a cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_seen_q <= 1'b0;
        end else begin
            fault_seen_q <= !pins.fault_output_n;
        end
    end

    assign fault_seen_o = fault_seen_q;
    assign pins.channel_level_input = level_q;
    assign pins.channel_output_enable = enable_q;
    assign pins.active_low_reset_input_n = reset_n_q;
    assign pins.sleep_request_input_n = sleep_n_q;

endmodule

// ### qhbc_sva.sv
/* checker of the quad half-bridge pins and device outputs.
   assumes one clock, instantiated beside the interface. */
`timescale 1ns/100ps
module qhbc_sva
    import qhbc_pkg::*;
#(
    parameter int WAKE_CYCLES = QHBC_WAKE_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] channel_level_input,
    input wire logic [3:0] channel_output_enable,
    input wire logic active_low_reset_input_n,
    input wire logic sleep_request_input_n,
    input wire logic fault_output_o,
    input wire logic fault_output_oe,
    input wire logic [3:0] hs_limit_i,
    input wire logic [3:0] ls_limit_i,
    input wire logic [QHBC_TEMP_W-1:0] die_temp_i,
    input wire logic supply_good_i,
    input wire logic [3:0] channel_output_o,
    input wire logic [3:0] channel_output_oe_o,
    input wire logic charge_pump_on_o,
    input wire logic regulator_on_o,
    input wire logic clocks_running_o,
    input wire logic operational_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic env_ok;
    logic no_lim;
    logic [15:0] wake_cnt_q;
    assign env_ok = supply_good_i && (die_temp_i <= QHBC_TSD_TRIP);
    assign no_lim = ((hs_limit_i | ls_limit_i) == 4'h0);
    // cycles since the sleep pin went high, saturating
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_cnt_q <= 16'h0000;
        end else if (!sleep_request_input_n) begin
            wake_cnt_q <= 16'h0000;
        end else if (wake_cnt_q != 16'hffff) begin
            wake_cnt_q <= wake_cnt_q + 16'h0001;
        end
    end
    sequence s_run;
        operational_o && sleep_request_input_n && active_low_reset_input_n;
    endsequence
    sequence s_quiet;
        env_ok && no_lim && active_low_reset_input_n;
    endsequence
    property p_follow;
        s_quiet ##1 (s_run and s_quiet) ##0 !fault_output_oe |=>
            channel_output_oe_o == $past(channel_output_enable) &&
            ((channel_output_o ^ $past(channel_level_input))
             & channel_output_oe_o) == 4'h0;
    endproperty
    a_follow: assert property (p_follow) else $error("output not following pins");
    property p_reset_off;
        !active_low_reset_input_n |=> channel_output_oe_o == 4'h0;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("driven in reset");
    property p_sleep_off;
        !sleep_request_input_n |=> channel_output_oe_o == 4'h0 &&
            !charge_pump_on_o && !clocks_running_o;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("active in sleep");
    property p_sleep_ignore;
        !sleep_request_input_n ##1 !sleep_request_input_n |=> !operational_o;
    endproperty
    a_sleep_ignore: assert property (p_sleep_ignore) else $error("operational in sleep");
    property p_wake;
        $rose(operational_o) |-> wake_cnt_q >= WAKE_CYCLES + 2;
    endproperty
    a_wake: assert property (p_wake) else $error("woke too early");
    property p_regulator;
        !sleep_request_input_n ##1 !sleep_request_input_n |-> regulator_on_o;
    endproperty
    a_regulator: assert property (p_regulator) else $error("regulator off");
    property p_latch;
        s_quiet [*2] ##1 (s_quiet and fault_output_oe) |=> fault_output_oe;
    endproperty
    a_latch: assert property (p_latch) else $error("latch lost");
    property p_thermal;
        die_temp_i > QHBC_TSD_TRIP && sleep_request_input_n |-> ##2
            fault_output_oe && channel_output_oe_o == 4'h0;
    endproperty
    a_thermal: assert property (p_thermal) else $error("no thermal stop");
    property p_undervoltage_lockout;
        !supply_good_i && sleep_request_input_n |=>
            fault_output_oe && channel_output_oe_o == 4'h0;
    endproperty
    a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("no supply lockout");
    property p_od;
        fault_output_oe |-> !fault_output_o;
    endproperty
    a_od: assert property (p_od) else $error("fault drives high");
    property p_release;
        (env_ok && !active_low_reset_input_n) ##1 env_ok |=> !fault_output_oe;
    endproperty
    a_release: assert property (p_release) else $error("fault held");
endmodule

// ### qhbc_test.sv
/* testbench: host and device joined by the pin interface.
   assumes the fault wire has a pull-up resolved here. */
`timescale 1ns/100ps
module qhbc_test
    import qhbc_pkg::*;
;
    localparam int WAKE = 20;
    logic clk, rst_n, run, slp, clr, pwm, sup, seen, rdy;
    logic pump, regl, clks, op;
    qhbc_mode_t mode;
    logic [1:0] alv, aen;
    logic [3:0] hs, ls, out, oe;
    logic [7:0] temp;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    qhbc_if bus();
    // open-drain wire with pull-up
    assign bus.fault_output_n = bus.fault_output_oe ? bus.fault_output_o : 1'b1;
    qhbc_device #(.WAKE_CYCLES(WAKE)) u_qhbc_device (.core_clk_i(clk),
        .rst_n_i(rst_n), .pins(bus), .hs_limit_i(hs), .ls_limit_i(ls),
        .die_temp_i(temp), .supply_good_i(sup), .channel_output_o(out),
        .channel_output_oe_o(oe), .charge_pump_on_o(pump),
        .regulator_on_o(regl), .clocks_running_o(clks), .operational_o(op));
    qhbc_host u_qhbc_host (.core_clk_i(clk), .rst_n_i(rst_n), .pins(bus),
        .run_i(run), .sleep_req_i(slp), .clear_fault_i(clr), .mode_i(mode),
        .pwm_i(pwm), .aux_level_i(alv), .aux_enable_i(aen),
        .fault_seen_o(seen), .ready_o(rdy));
    qhbc_sva #(.WAKE_CYCLES(WAKE)) u_qhbc_sva (.core_clk_i(clk),
        .rst_n_i(rst_n), .channel_level_input(bus.channel_level_input),
        .channel_output_enable(bus.channel_output_enable),
        .active_low_reset_input_n(bus.active_low_reset_input_n),
        .sleep_request_input_n(bus.sleep_request_input_n),
        .fault_output_o(bus.fault_output_o),
        .fault_output_oe(bus.fault_output_oe), .hs_limit_i(hs),
        .ls_limit_i(ls), .die_temp_i(temp), .supply_good_i(sup),
        .channel_output_o(out), .channel_output_oe_o(oe),
        .charge_pump_on_o(pump), .regulator_on_o(regl),
        .clocks_running_o(clks), .operational_o(op));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic chk4(input string what, input logic [3:0] e,
                        input logic [3:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkn(input string what, input int e, input int g);
        checks_done++;
        if (g != e) begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, g);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bounded wait: sleep pin high, then count cycles to operational
    task automatic wait_op(output int k);
        k = 0;
        while (bus.sleep_request_input_n !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        k = 0;
        while (op !== 1'b1 && k < 200) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic t_modes();
        logic [3:0] lv, en;
        for (int i = 0; i < 10; i++) begin
            mode = qhbc_mode_t'(i / 2);
            pwm = i[0];
            alv = i[1:0];
            aen = i[2:1];
            case (mode)
                QHBC_MODE_FWD_SLOW: {lv, en} = {alv, 1'b0, pwm, aen, 2'b11};
                QHBC_MODE_REV_SLOW: {lv, en} = {alv, pwm, 1'b0, aen, 2'b11};
                QHBC_MODE_FWD_FAST: {lv, en} = {alv, 2'b01, aen, pwm, pwm};
                QHBC_MODE_REV_FAST: {lv, en} = {alv, 2'b10, aen, pwm, pwm};
                default: {lv, en} = {alv, 2'b00, aen, 2'b00};
            endcase
            cyc(3);
            chk4("pin enable", en, bus.channel_output_enable);
            chk4("pin level", lv & en, bus.channel_level_input & en);
            chk4("out enable", en, oe);
            chk4("out level", lv & en, out & en);
        end
    endtask
    task automatic t_ocp(input logic low, input int ch);
        logic [3:0] m;
        m = 4'h1 << ch;
        mode = QHBC_MODE_FWD_SLOW;
        pwm = 1'b1;
        aen = 2'b11;
        for (int k = 248; k < 260; k += 7) begin
            {hs, ls} = low ? {4'h0, m} : {m, 4'h0};
            cyc(k);
            {hs, ls} = 8'h00;
            cyc(3);
            chk4("fault pin", {3'h0, k < 250}, {3'h0, bus.fault_output_n});
        end
        chk4("trip enable", ~m, oe);
        cyc(20);
        chk4("latched fault", 4'h1, {3'h0, seen});
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        wait_op(n);
        cyc(3);
        chk4("cleared fault", 4'h1, {3'h0, bus.fault_output_n});
        chk4("cleared enable", 4'hf, oe);
    endtask
    task automatic t_shut(input logic uv);
        if (!uv) begin
            temp = 8'h96;
            cyc(3);
            chk4("trip point", 4'h1, {3'h0, bus.fault_output_n});
        end
        {sup, temp} = uv ? {1'b0, 8'h19} : {1'b1, 8'h97};
        cyc(3);
        chk4("shut fault", 4'h0, {3'h0, bus.fault_output_n});
        chk4("shut enable", 4'h0, oe);
        {sup, temp} = {1'b1, 8'h19};
        wait_op(n);
        cyc(3);
        chk4("resume fault", 4'h1, {3'h0, bus.fault_output_n});
        chk4("resume enable", 4'hf, oe);
    endtask
    task automatic t_sleep();
        slp = 1'b1;
        cyc(3);
        chk4("sleep state", 4'b0010, {pump, clks, regl, op});
        mode = QHBC_MODE_FWD_FAST;
        cyc(3);
        chk4("sleep enable", 4'h0, oe);
        slp = 1'b0;
        wait_op(n);
        chkn("rewake cycles", WAKE + 2, n);
        cyc(2);
        chk4("rewake enable", 4'hf, oe);
    endtask
    initial begin
        {rst_n, run, slp, clr, pwm, hs, ls} = 13'h0;
        mode = QHBC_MODE_COAST;
        {alv, aen, sup, temp} = {4'h0, 1'b1, 8'h19};
        cyc(5);
        rst_n = 1'b1;
        run = 1'b1;
        wait_op(n);
        chkn("wake cycles", WAKE + 2, n);
        chk4("host ready", 4'h0, {3'h0, rdy});
        t_modes();
        t_ocp(1'b0, 0);
        t_ocp(1'b1, 2);
        t_shut(1'b0);
        t_shut(1'b1);
        t_sleep();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
